// >>> pkg/tec16_pkg.sv
// Types shared by the 16-bit timer/event counter.
`default_nettype none
package tec16_pkg;
  // Phase of a one-shot pulse.
  typedef enum logic [1:0] {TEC16_OS_IDLE, TEC16_OS_WAIT_ON, TEC16_OS_ON} tec16_os_state_t;
  // Valid edge choice of the trigger/capture input.
  typedef enum logic [1:0] {TEC16_ES_FALL, TEC16_ES_RISE, TEC16_ES_BOTH, TEC16_ES_BOTH2} tec16_edge_t;
  // AXI response codes.
  typedef logic [1:0] tec16_resp_t;
endpackage
`default_nettype wire

// >>> pkg/tec16_regs.svh
// Register offsets, field positions, reset values and timing counts of the 16-bit timer/event counter.
`ifndef TEC16_REGS_SVH
`define TEC16_REGS_SVH
// ****************************************************************
// Register byte offsets
// ****************************************************************
`define TEC16_MODE_OFS 5'h00
`define TEC16_OUTC_OFS 5'h04
`define TEC16_EDGE_OFS 5'h08
`define TEC16_CMP_OFS 5'h0C
`define TEC16_AUX_OFS 5'h10
`define TEC16_CNT_OFS 5'h14
`define TEC16_STAT_OFS 5'h18
`define TEC16_MASK_OFS 5'h1C
// ****************************************************************
// Field positions and codes
// ****************************************************************
`define TEC16_MODE_LSB 1
`define TEC16_MODE_MSB 3
`define TEC16_MODE_STOP 3'h0
`define TEC16_MODE_CLR_MATCH 3'h3
`define TEC16_OE_BIT 0
`define TEC16_TOGGLE_BIT 1
`define TEC16_OS_EN_BIT 2
`define TEC16_OS_EXT_BIT 3
`define TEC16_CAP_EN_BIT 4
`define TEC16_EXT_CNT_BIT 5
`define TEC16_ONESHOT_SOFTWARE_TRIGGER_BIT 6
`define TEC16_ES_LSB 2
`define TEC16_ES_MSB 3
`define TEC16_ST_MATCH 0
`define TEC16_ST_EDGE 1
`define TEC16_ST_OVF 2
// ****************************************************************
// Reset values and timing
// ****************************************************************
`define TEC16_CMP_RST 16'hFFFF
`define TEC16_CLK_NS 5
`define TEC16_SAMPLE_NS 20
`define TEC16_SAMPLE_CYC ((`TEC16_SAMPLE_NS + `TEC16_CLK_NS - 1) / `TEC16_CLK_NS)
`endif

// >>> rtl/tec16_top.sv
// 16-bit timer/event counter with compare, capture/compare, one-shot and AXI4-Lite registers.
`default_nettype none
`include "tec16_regs.svh"
module tec16_top #(
  parameter int PRESCALE = 1,                   // Clocks per internal count pulse.
  parameter int SAMPLE_DIV = `TEC16_SAMPLE_CYC  // Clocks between two filter samples.
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [4:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output tec16_pkg::tec16_resp_t s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [4:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output tec16_pkg::tec16_resp_t s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic trigger_capture_input_i,
  output logic timer_output_pin_o,
  output logic irq_o
);
  import tec16_pkg::*;

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  if (PRESCALE < 1 || PRESCALE > 65536) begin : g_bad_prescale
    $error("PRESCALE must lie between 1 and 65536.");
  end
  if (SAMPLE_DIV < 1 || SAMPLE_DIV > 65536) begin : g_bad_sample
    $error("SAMPLE_DIV must lie between 1 and 65536.");
  end

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic rst_meta; // First release stage, read only by the second.
  logic rst_n;    // Released reset used by the whole design.

  // Assert at once, release after two clock edges.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ****************************************************************
  // Registers and internal state
  // ****************************************************************
  logic [2:0] mode_bits;                // Operating mode bits of timer_mode_control.
  logic [6:0] timer_output_control;     // Output, one-shot, capture and source controls.
  logic [1:0] edge_sel;                 // Valid edge selection field.
  logic [15:0] compare_value_register;  // Compare value.
  logic [15:0] capture_compare_aux_register; // Capture value or one-shot start point.
  logic [15:0] main_count_register;     // The up counter.
  logic [2:0] status;                   // Sticky event flags.
  logic [2:0] mask;                     // Interrupt enables.
  tec16_os_state_t os_state;            // One-shot pulse phase.
  logic running;                        // Mode bits are nonzero.
  logic clr_mode;                       // Clear and start on match is selected.

  assign running = (mode_bits != `TEC16_MODE_STOP);
  assign clr_mode = (mode_bits == `TEC16_MODE_CLR_MATCH);

  // ****************************************************************
  // AXI4-Lite write channel
  // ****************************************************************
  logic aw_held;         // Write address taken and waiting.
  logic w_held;          // Write data taken and waiting.
  logic [4:0] aw_addr;   // Captured write address.
  logic [31:0] w_data;   // Captured write data.
  logic [3:0] w_strb;    // Captured byte strobes.
  logic wr_do;           // Both halves are here: perform the write this cycle.
  logic wr_hit;          // Write address decodes to a writable register (not the count).

  assign wr_do = aw_held && w_held && !s_axi_bvalid_o;
  assign wr_hit = (aw_addr[4:2] != 3'h5) && (aw_addr[1:0] == 2'h0);

  // Merges the strobed bytes of new data into an old word.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[8*b +: 8] = d[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Address and data are taken in either order, each held until the write is done.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 5'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o <= 1'b0;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr_i;
      end else if (wr_do) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata_i;
        w_strb <= s_axi_wstrb_i;
      end else if (wr_do) begin
        w_held <= 1'b0;
      end
      // Ready is offered only while that half is empty and no answer is pending.
      s_axi_awready_o <= !aw_held && !(s_axi_awvalid_i && s_axi_awready_o) && !s_axi_bvalid_o && !wr_do;
      s_axi_wready_o <= !w_held && !(s_axi_wvalid_i && s_axi_wready_o) && !s_axi_bvalid_o && !wr_do;
    end
  end

  // Write response one cycle after the write is performed.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= 2'h0;
    end else if (wr_do) begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o <= wr_hit ? 2'h0 : 2'h2;
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  // ****************************************************************
  // AXI4-Lite read channel
  // ****************************************************************
  logic rd_take;     // Read address accepted this cycle.
  logic aux_read;    // The capture register is being read this cycle.

  assign rd_take = s_axi_arvalid_i && s_axi_arready_o;
  assign aux_read = rd_take && (s_axi_araddr_i[4:2] == 3'h4);

  // Read data are sampled at the address handshake and held until taken.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0000_0000;
      s_axi_rresp_o <= 2'h0;
    end else begin
      s_axi_arready_o <= !s_axi_rvalid_o && !rd_take;
      if (rd_take) begin
        s_axi_rvalid_o <= 1'b1;
        s_axi_rresp_o <= (s_axi_araddr_i[1:0] == 2'h0) ? 2'h0 : 2'h2;
        case (s_axi_araddr_i)
          `TEC16_MODE_OFS: s_axi_rdata_o <= {28'h0, mode_bits, 1'b0};
          `TEC16_OUTC_OFS: s_axi_rdata_o <= {26'h0, timer_output_control[5:0]};
          `TEC16_EDGE_OFS: s_axi_rdata_o <= {28'h0, edge_sel, 2'h0};
          `TEC16_CMP_OFS: s_axi_rdata_o <= {16'h0, compare_value_register};
          `TEC16_AUX_OFS: s_axi_rdata_o <= {16'h0, capture_compare_aux_register};
          `TEC16_CNT_OFS: s_axi_rdata_o <= {16'h0, main_count_register};
          `TEC16_STAT_OFS: s_axi_rdata_o <= {29'h0, status};
          `TEC16_MASK_OFS: s_axi_rdata_o <= {29'h0, mask};
          default: s_axi_rdata_o <= 32'h0000_0000;
        endcase
      end else if (s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Control register writes
  // ****************************************************************
  logic [31:0] wr_mode; // Merged words for each plain stored register.
  logic [31:0] wr_outc;
  logic [31:0] wr_edge;
  logic [31:0] wr_cmp;
  logic [31:0] wr_mask;
  logic [31:0] wr_aux;  // Merged word for the aux register.
  logic sw_trigger;     // Software one-shot trigger, one cycle.

  assign wr_mode = merge({28'h0, mode_bits, 1'b0}, w_data, w_strb);
  assign wr_outc = merge({25'h0, timer_output_control}, w_data, w_strb);
  assign wr_edge = merge({28'h0, edge_sel, 2'h0}, w_data, w_strb);
  assign wr_cmp = merge({16'h0, compare_value_register}, w_data, w_strb);
  assign wr_mask = merge({29'h0, mask}, w_data, w_strb);
  assign wr_aux = merge({16'h0, capture_compare_aux_register}, w_data, w_strb);
  assign sw_trigger = wr_do && (aw_addr == `TEC16_OUTC_OFS) && wr_outc[`TEC16_ONESHOT_SOFTWARE_TRIGGER_BIT];

  // Plain stored registers; the trigger bit never stays set.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      mode_bits <= `TEC16_MODE_STOP;
      timer_output_control <= 7'h00;
      edge_sel <= 2'h0;
      compare_value_register <= `TEC16_CMP_RST;
      mask <= 3'h0;
    end else if (wr_do) begin
      case (aw_addr)
        `TEC16_MODE_OFS: mode_bits <= wr_mode[`TEC16_MODE_MSB:`TEC16_MODE_LSB];
        `TEC16_OUTC_OFS: timer_output_control <= {1'b0, wr_outc[5:0]};
        `TEC16_EDGE_OFS: edge_sel <= wr_edge[`TEC16_ES_MSB:`TEC16_ES_LSB];
        `TEC16_CMP_OFS: compare_value_register <= wr_cmp[15:0];
        `TEC16_MASK_OFS: mask <= wr_mask[2:0];
        default: mask <= mask;
      endcase
    end
  end

  // ****************************************************************
  // Input edge filter
  // ****************************************************************
  logic [15:0] samp_cnt;  // Divides the clock down to the sampling interval.
  logic samp_prev;        // Previous sample of the input.
  logic samp_level;       // Filtered input level.
  logic valid_edge;       // A selected edge passed the filter, one cycle.
  logic rise;
  logic fall;

  // A new level is accepted only when two consecutive samples agree on it.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      samp_cnt <= 16'h0000;
      samp_prev <= 1'b0;
      samp_level <= 1'b0;
      rise <= 1'b0;
      fall <= 1'b0;
    end else begin
      rise <= 1'b0;
      fall <= 1'b0;
      if (samp_cnt == 16'(SAMPLE_DIV - 1)) begin
        samp_cnt <= 16'h0000;
        samp_prev <= trigger_capture_input_i;
        if (trigger_capture_input_i == samp_prev && samp_prev != samp_level) begin
          samp_level <= samp_prev;
          rise <= samp_prev;
          fall <= !samp_prev;
        end
      end else begin
        samp_cnt <= samp_cnt + 16'h0001;
      end
    end
  end

  // Edge selection: rising, falling, or both.
  always_comb begin
    case (tec16_edge_t'(edge_sel))
      TEC16_ES_FALL: valid_edge = fall;
      TEC16_ES_RISE: valid_edge = rise;
      default: valid_edge = rise || fall;
    endcase
  end

  // ****************************************************************
  // Count pulse
  // ****************************************************************
  logic [15:0] pre_cnt; // Internal prescaler; free running, so a start is not aligned to it.
  logic tick;           // One count pulse.

  // The prescaler is never reset by a start, which gives the start error of up to one pulse.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pre_cnt <= 16'h0000;
    end else if (pre_cnt == 16'(PRESCALE - 1)) begin
      pre_cnt <= 16'h0000;
    end else begin
      pre_cnt <= pre_cnt + 16'h0001;
    end
  end

  assign tick = running &&
    (timer_output_control[`TEC16_EXT_CNT_BIT] ? valid_edge : (pre_cnt == 16'(PRESCALE - 1)));

  // ****************************************************************
  // Counter, one-shot and output
  // ****************************************************************
  logic ext_trigger;  // External one-shot trigger accepted.
  logic os_start;     // One-shot start from either source.
  logic [15:0] next_count;
  logic cmp_hit;      // Count pulse moves the counter onto the compare value.
  logic aux_hit;      // Count pulse moves the counter onto the aux value.

  assign ext_trigger = timer_output_control[`TEC16_OS_EN_BIT] && timer_output_control[`TEC16_OS_EXT_BIT] &&
    valid_edge && (os_state == TEC16_OS_IDLE);
  assign os_start = running && (ext_trigger || (sw_trigger && wr_outc[`TEC16_OS_EN_BIT]));

  // Clear mode wraps to zero on the pulse after the match; otherwise plain increment with wrap.
  always_comb begin
    if (clr_mode && main_count_register == compare_value_register) begin
      next_count = 16'h0000;
    end else begin
      next_count = main_count_register + 16'h0001;
    end
  end

  assign cmp_hit = tick && !os_start && (next_count == compare_value_register);
  assign aux_hit = tick && !os_start && (next_count == capture_compare_aux_register);

  // Counter: cleared while stopped and on a one-shot trigger.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      main_count_register <= 16'h0000;
    end else if (!running) begin
      main_count_register <= 16'h0000;
    end else if (os_start) begin
      main_count_register <= 16'h0000;
    end else if (tick) begin
      main_count_register <= next_count;
    end
  end

  // One-shot phase: wait for the aux match, then hold until the compare match.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      os_state <= TEC16_OS_IDLE;
    end else if (!running) begin
      os_state <= TEC16_OS_IDLE;
    end else begin
      case (os_state)
        TEC16_OS_IDLE: if (os_start) begin
          os_state <= (capture_compare_aux_register == 16'h0000) ? TEC16_OS_ON : TEC16_OS_WAIT_ON;
        end
        TEC16_OS_WAIT_ON: if (aux_hit) begin
          os_state <= TEC16_OS_ON;
        end
        TEC16_OS_ON: if (cmp_hit) begin
          os_state <= TEC16_OS_IDLE;
        end
        default: os_state <= TEC16_OS_IDLE;
      endcase
    end
  end

  // Output pin: one-shot level, or toggle on each compare match.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      timer_output_pin_o <= 1'b0;
    end else if (!timer_output_control[`TEC16_OE_BIT]) begin
      timer_output_pin_o <= 1'b0;
    end else if (timer_output_control[`TEC16_OS_EN_BIT]) begin
      if (os_start && capture_compare_aux_register == 16'h0000) begin
        timer_output_pin_o <= 1'b1;
      end else if (os_state == TEC16_OS_WAIT_ON && aux_hit) begin
        timer_output_pin_o <= 1'b1;
      end else if (os_state == TEC16_OS_ON && cmp_hit) begin
        timer_output_pin_o <= 1'b0;
      end
    end else if (timer_output_control[`TEC16_TOGGLE_BIT] && cmp_hit) begin
      timer_output_pin_o <= !timer_output_pin_o;
    end
  end

  // Capture on a valid edge, unless the register is being read in the same cycle.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      capture_compare_aux_register <= 16'h0000;
    end else if (wr_do && aw_addr == `TEC16_AUX_OFS) begin
      capture_compare_aux_register <= wr_aux[15:0];
    end else if (timer_output_control[`TEC16_CAP_EN_BIT] && valid_edge && !aux_read) begin
      capture_compare_aux_register <= main_count_register;
    end
  end

  // ****************************************************************
  // Status flags and interrupt
  // ****************************************************************
  logic [2:0] st_set;   // Events this cycle.
  logic [2:0] st_clr;   // Write-one-to-clear bits this cycle.

  assign st_set[`TEC16_ST_MATCH] = cmp_hit;
  assign st_set[`TEC16_ST_EDGE] = valid_edge;
  assign st_set[`TEC16_ST_OVF] = tick && clr_mode && !os_start &&
    compare_value_register == 16'hFFFF && main_count_register == 16'hFFFF;
  assign st_clr = (wr_do && aw_addr == `TEC16_STAT_OFS) ? (w_data[2:0] & {3{w_strb[0]}}) : 3'h0;

  // A set in the same cycle as a clear wins.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      status <= 3'h0;
    end else begin
      status <= (status & ~st_clr) | st_set;
    end
  end

  // Level interrupt while any unmasked flag is set.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(status & mask);
    end
  end

endmodule // tec16_top
`default_nettype wire

// >>> testbench/tec16_props.sv
// Port-level assertions for the 16-bit timer/event counter.
`default_nettype none
module tec16_props (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [4:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire tec16_pkg::tec16_resp_t s_axi_bresp_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [4:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire tec16_pkg::tec16_resp_t s_axi_rresp_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic irq_o
);
  timeunit 1ns;
  timeprecision 100ps;
  import tec16_pkg::*;
  // ****************************************************************
  // Bus and interrupt checks
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // An answer stays put until the master takes it.
  a_bresp_holds: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write answer dropped early");
  a_rdata_holds: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read answer changed early");
  // Answers come at the cycle the hand-over fixes.
  a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read answer late");
  a_write_answer: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
    |-> ##2 s_axi_bvalid_o) else $error("write answer late");
  // Misaligned reads are refused with zero data.
  a_misalign_refused: assert property (s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i[1:0] != 2'h0
    |=> s_axi_rresp_o == 2'h2 && s_axi_rdata_o == 32'h0) else $error("misaligned read accepted");
  // The running count cannot be written.
  a_count_readonly: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
    && s_axi_awaddr_i == 5'h14 |-> ##2 s_axi_bresp_o == 2'h2) else $error("count write accepted");
  // No new read is taken while an answer waits.
  a_read_single: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read taken while answer pending");
  // Status bits are sticky: the request only drops soon after a register write.
  a_irq_sticky: assert property ($fell(irq_o) |-> $past(s_axi_awvalid_i && s_axi_awready_o, 1)
    || $past(s_axi_awvalid_i && s_axi_awready_o, 2) || $past(s_axi_awvalid_i && s_axi_awready_o, 3)
    || $past(s_axi_awvalid_i && s_axi_awready_o, 4)) else $error("interrupt dropped without a write");
endmodule // tec16_props
bind tec16_top tec16_props i_props (.clk_i(clk_i), .rst_b_i(rst_b_i), .s_axi_awaddr_i(s_axi_awaddr_i),
  .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o), .s_axi_wvalid_i(s_axi_wvalid_i),
  .s_axi_wready_o(s_axi_wready_o), .s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o),
  .s_axi_bready_i(s_axi_bready_i), .s_axi_araddr_i(s_axi_araddr_i), .s_axi_arvalid_i(s_axi_arvalid_i),
  .s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rresp_o(s_axi_rresp_o),
  .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i), .irq_o(irq_o));
`default_nettype wire

// >>> testbench/testbench.sv
// Self-checking testbench of the 16-bit timer/event counter.
`default_nettype none
`include "tec16_regs.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin failures++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import tec16_pkg::*;
  localparam logic [31:0] MCLR = 32'h6; // Clear-and-start on match.
  localparam logic [31:0] MRUN = 32'h2; // Free run.
  logic clk_i, rst_b_i, awvalid, wvalid, arvalid, trig, awready, wready, bvalid, arready, rvalid, pin, irq, brdy, rrdy;
  logic [4:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  tec16_resp_t bresp, rresp;
  int failures = 0;
  int tests_run = 0;
  int cycles = 0;
  int n;
  // Short prescale and filter keep every count visible in cycles.
  tec16_top #(.PRESCALE(1), .SAMPLE_DIV(1)) i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(brdy), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rrdy),
    .trigger_capture_input_i(trig), .timer_output_pin_o(pin), .irq_o(irq));
  // ****************************************************************
  // Clock, watchdog and verdict
  // ****************************************************************
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  task automatic give_verdict();
    if (failures == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // The overflow run dominates at about 67000 cycles.
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 80000) begin
      failures++;
      give_verdict();
    end
  end
  // ****************************************************************
  // Bus and pin helpers
  // ****************************************************************
  task automatic axw(input logic [4:0] a, input logic [31:0] d, input tec16_resp_t er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    brdy <= 1'b0;
    do begin
      @(posedge clk_i);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid && !brdy) brdy <= 1'b1;
    end while (!(bvalid === 1'b1 && brdy === 1'b1));
    `CHK(bresp, er)
  endtask
  task automatic axr(input logic [4:0] a, input tec16_resp_t er, output logic [31:0] d);
    araddr <= a;
    arvalid <= 1'b1;
    rrdy <= 1'b0;
    do begin
      @(posedge clk_i);
      if (arready) arvalid <= 1'b0;
      if (rvalid && !rrdy) rrdy <= 1'b1;
    end while (!(rvalid === 1'b1 && rrdy === 1'b1));
    d = rdata;
    `CHK(rresp, er)
  endtask
  task automatic chk_rd(input logic [4:0] a, input logic [31:0] e);
    axr(a, 2'h0, rd);
    `CHK(rd, e)
  endtask
  task automatic wait_pin(input logic lvl);
    while (pin !== lvl) @(posedge clk_i);
  endtask
  // Counts the edges for which the output stays high.
  task automatic hi_len(output int k);
    k = 0;
    while (pin === 1'b1) begin
      @(posedge clk_i);
      k++;
    end
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_regs();
    chk_rd(`TEC16_CMP_OFS, 32'h0000FFFF);
    axw(`TEC16_CNT_OFS, 32'h5, 2'h2);
    chk_rd(`TEC16_CNT_OFS, 32'h0);
    axr(5'h02, 2'h2, rd);
    `CHK(rd, 32'h0)
  endtask
  task automatic t_interval();
    axw(`TEC16_CMP_OFS, 32'd20, 2'h0);
    axw(`TEC16_MASK_OFS, 32'h1, 2'h0);
    axw(`TEC16_MODE_OFS, MCLR, 2'h0);
    while (irq !== 1'b1) @(posedge clk_i);
    chk_rd(`TEC16_STAT_OFS, 32'h1);
    axw(`TEC16_MASK_OFS, 32'h0, 2'h0);
    repeat (2) @(posedge clk_i);
    `CHK(irq, 1'b0)
    axw(`TEC16_MODE_OFS, 32'h0, 2'h0);
    axw(`TEC16_STAT_OFS, 32'h1, 2'h0);
    chk_rd(`TEC16_STAT_OFS, 32'h0);
    chk_rd(`TEC16_CNT_OFS, 32'h0);
  endtask
  task automatic t_square();
    axw(`TEC16_CMP_OFS, 32'd10, 2'h0);
    axw(`TEC16_OUTC_OFS, 32'h3, 2'h0);
    axw(`TEC16_MODE_OFS, MCLR, 2'h0);
    wait_pin(1'b1);
    hi_len(n);
    `CHK(n, 11)
    axw(`TEC16_MODE_OFS, 32'h0, 2'h0);
    axw(`TEC16_OUTC_OFS, 32'h0, 2'h0);
  endtask
  task automatic t_wrap_ovf();
    axw(`TEC16_CMP_OFS, 32'h8000, 2'h0);
    axw(`TEC16_MASK_OFS, 32'h4, 2'h0);
    axw(`TEC16_MODE_OFS, MCLR, 2'h0);
    repeat (512) @(posedge clk_i);
    axw(`TEC16_CMP_OFS, 32'h10, 2'h0);
    axw(`TEC16_STAT_OFS, 32'h7, 2'h0);
    repeat (1000) @(posedge clk_i);
    chk_rd(`TEC16_STAT_OFS, 32'h0);
    axw(`TEC16_MODE_OFS, 32'h0, 2'h0);
    axw(`TEC16_CMP_OFS, 32'hFFFF, 2'h0);
    axw(`TEC16_STAT_OFS, 32'h7, 2'h0);
    axw(`TEC16_MODE_OFS, MCLR, 2'h0);
    while (irq !== 1'b1) @(posedge clk_i);
    chk_rd(`TEC16_STAT_OFS, 32'h5);
    axw(`TEC16_MODE_OFS, 32'h0, 2'h0);
    axw(`TEC16_STAT_OFS, 32'h7, 2'h0);
  endtask
  task automatic t_capture();
    axw(`TEC16_AUX_OFS, 32'h0, 2'h0);
    axw(`TEC16_EDGE_OFS, 32'h4, 2'h0);
    axw(`TEC16_OUTC_OFS, 32'h10, 2'h0);
    axw(`TEC16_MODE_OFS, MRUN, 2'h0);
    repeat (5) @(posedge clk_i);
    trig <= 1'b1;
    repeat (10) @(posedge clk_i);
    axr(`TEC16_AUX_OFS, 2'h0, rd);
    `CHK(rd != 32'h0, 1'b1)
    chk_rd(`TEC16_STAT_OFS, 32'h2);
    axw(`TEC16_STAT_OFS, 32'h2, 2'h0);
    trig <= 1'b0;
    repeat (10) @(posedge clk_i);
    chk_rd(`TEC16_STAT_OFS, 32'h0);
    trig <= 1'b1;
    @(posedge clk_i);
    trig <= 1'b0;
    repeat (10) @(posedge clk_i);
    chk_rd(`TEC16_STAT_OFS, 32'h0);
    axr(`TEC16_AUX_OFS, 2'h0, rd);
    n = rd;
    trig <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk_rd(`TEC16_AUX_OFS, n);
    chk_rd(`TEC16_AUX_OFS, n);
    chk_rd(`TEC16_STAT_OFS, 32'h2);
    trig <= 1'b0;
    axw(`TEC16_MODE_OFS, 32'h0, 2'h0);
  endtask
  task automatic t_oneshot();
    axw(`TEC16_CMP_OFS, 32'd30, 2'h0);
    axw(`TEC16_AUX_OFS, 32'd10, 2'h0);
    axw(`TEC16_MODE_OFS, MRUN, 2'h0);
    axw(`TEC16_OUTC_OFS, 32'h45, 2'h0);
    wait_pin(1'b1);
    hi_len(n);
    `CHK(n, 20)
    axw(`TEC16_MODE_OFS, 32'h0, 2'h0);
    axw(`TEC16_OUTC_OFS, 32'hD, 2'h0);
    axw(`TEC16_MODE_OFS, MRUN, 2'h0);
    trig <= 1'b1;
    wait_pin(1'b1);
    repeat (3) @(posedge clk_i);
    trig <= 1'b0;
    repeat (4) @(posedge clk_i);
    trig <= 1'b1;
    hi_len(n);
    `CHK(n + 7, 20)
  endtask
  initial begin
    rst_b_i = 1'b0;
    {awvalid, wvalid, arvalid, trig, awaddr, araddr, wdata, brdy, rrdy} = '0;
    repeat (4) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    t_regs();
    t_interval();
    t_square();
    t_wrap_ovf();
    t_capture();
    t_oneshot();
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
